// >>> dv/mie_core_chk.sv
// Port-level assertions for the instruction execute block
module mie_core_chk
  import mie_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SLEEP_O,
  input wire logic GIE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address and data taken together; the bench always offers both at once
  logic wr_both;
  logic ex_ok;
  assign wr_both = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign ex_ok = wr_both && S_AXI_AWADDR_I == OFF_EXEC && !SLEEP_O;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  aw_accept_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O)
    else $error("AWREADY high after address taken");
  w_accept_a: assert property (S_AXI_WVALID_I && S_AXI_WREADY_O |=> !S_AXI_WREADY_O)
    else $error("WREADY high after data taken");
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped early");
  wr_answer_a: assert property (wr_both |-> ##[1:6] S_AXI_BVALID_O)
    else $error("write response missing");
  wr_unmapped_a: assert property (wr_both && S_AXI_AWADDR_I > 8'h20 |-> ##[1:6] (S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR))
    else $error("unmapped write not refused");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
    else $error("read answer late");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped early");
  rd_unmapped_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I > 8'h20
    |=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  gie_set_a: assert property (ex_ok && S_AXI_WDATA_I[20:16] == OP_INTERRUPT_ENABLE |-> ##[2:5] GIE_O)
    else $error("enable did not set GIE_O");
  gie_clear_a: assert property (ex_ok && S_AXI_WDATA_I[20:16] == OP_INTERRUPT_DISABLE |-> ##[2:5] !GIE_O)
    else $error("disable did not clear GIE_O");
endmodule : mie_core_chk

bind mie_core mie_core_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .SLEEP_O(SLEEP_O), .GIE_O(GIE_O));

// >>> dv/mie_core_tb_top.sv
// Self-checking bench for the instruction execute block
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module mie_core_tb_top
  import mie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] op;
    logic d;
    logic [9:0] im;
    logic [7:0] ac, r;
    logic [2:0] fi;
    logic [7:0] ea, er;
    logic [2:0] ef;
    logic [11:0] pc;
  } mie_row_type;
  // Row: opcode, dest, operand, acc, file value, flags in, then acc, file, flags {Z,DC,C} and PC expected
  localparam int NR = 30;
  mie_row_type rows [0:NR-1] = '{
    '{OP_DECREMENT_SKIP_ZERO, 1, 5, 'h33, 'h01, 0, 'h33, 'h00, 0, 'h102},
    '{OP_DECREMENT_SKIP_ZERO, 0, 5, 'h33, 'h05, 7, 'h04, 'h05, 7, 'h101},
    '{OP_INCREMENT, 0, 5, 'h12, 'hff, 0, 'h00, 'hff, 4, 'h101},
    '{OP_INCREMENT_SKIP_ZERO, 1, 5, 'h12, 'hff, 0, 'h12, 'h00, 0, 'h102},
    '{OP_JUMP, 0, 'h155, 'h12, 'h00, 3, 'h12, 'h00, 3, 'h955},
    '{OP_OR_WITH_REGISTER, 0, 5, 'h0f, 'hf0, 7, 'hff, 'hf0, 3, 'h101},
    '{OP_XOR_WITH_REGISTER, 1, 5, 'h5a, 'h5a, 0, 'h5a, 'h00, 4, 'h101},
    '{OP_OR_WITH_LITERAL, 0, 'h00, 'h00, 'h00, 3, 'h00, 'h00, 7, 'h101},
    '{OP_XOR_WITH_LITERAL, 0, 'hff, 'h0f, 'h11, 7, 'hf0, 'h11, 3, 'h101},
    '{OP_STORE_ACCUMULATOR, 0, 'h3f, 'ha5, 'h00, 5, 'ha5, 'ha5, 5, 'h101},
    '{OP_LOAD_LITERAL, 0, 'h3c, 'h00, 'h00, 2, 'h3c, 'h00, 2, 'h101},
    '{OP_REGISTER_MOVE, 1, 5, 'h77, 'h00, 0, 'h77, 'h00, 4, 'h101},
    '{OP_REGISTER_MOVE, 0, 5, 'h77, 'h80, 7, 'h80, 'h80, 3, 'h101},
    '{OP_ROTATE_LEFT_CARRY, 0, 5, 'h00, 'h81, 6, 'h02, 'h81, 7, 'h101},
    '{OP_ROTATE_RIGHT_CARRY, 1, 5, 'h00, 'h02, 5, 'h00, 'h81, 4, 'h101},
    '{OP_NIBBLE_EXCHANGE, 1, 5, 'h00, 'ha5, 2, 'h00, 'h5a, 2, 'h101},
    '{OP_SUBTRACT_REGISTER, 0, 5, 'h01, 'h10, 0, 'h0f, 'h10, 1, 'h101},
    '{OP_SUBTRACT_FROM_LITERAL, 0, 5, 'h05, 'h00, 0, 'h00, 'h00, 7, 'h101},
    '{OP_SUBTRACT_WITH_BORROW, 1, 5, 'h06, 'h05, 6, 'h06, 'hfe, 0, 'h101},
    '{OP_SUBTRACT_WITH_BORROW, 0, 5, 'h05, 'h05, 1, 'h00, 'h05, 7, 'h101},
    '{OP_TABLE_JUMP, 0, 5, 'h10, 'h00, 7, 'h10, 'h00, 0, 'h910},
    '{OP_SOFT_INTERRUPT, 0, 0, 'h00, 'h00, 0, 'h00, 'h00, 0, 'h002},
    '{OP_SUBROUTINE_RETURN, 0, 0, 'h44, 'h00, 7, 'h44, 'h00, 7, 'h101},
    '{OP_SOFT_INTERRUPT, 0, 0, 'h00, 'h00, 0, 'h00, 'h00, 0, 'h002},
    '{OP_RETURN_WITH_LITERAL, 0, 'h99, 'h00, 'h00, 0, 'h99, 'h00, 0, 'h101},
    '{OP_CONFIG_REGISTER_WRITE, 0, 0, 'h3c, 'h00, 0, 'h3c, 'h00, 0, 'h101},
    '{OP_CONFIG_REGISTER_READ, 0, 0, 'h00, 'h00, 0, 'h3c, 'h00, 0, 'h101},
    '{OP_PORT_DIRECTION_WRITE, 0, 5, 'hc3, 'h00, 0, 'hc3, 'h00, 0, 'h101},
    '{OP_PORT_DIRECTION_READ, 0, 5, 'h00, 'h00, 0, 'hc3, 'h00, 0, 'h101},
    '{OP_PORT_DIRECTION_READ, 0, 'h0a, 'h11, 'h00, 0, 'h11, 'h00, 0, 'h101}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sleep, global_interrupt_enable;
  logic [1:0] bresp, rresp, bres, rres;
  logic [31:0] rdata, rdat;
  int failures = 0, total_checks = 0, cyc = 0;
  mie_row_type rw;

  mie_core u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .SLEEP_O(sleep), .GIE_O(global_interrupt_enable));

  // Clock and hang guard; the limit is well above the whole sequence
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Bus write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ga = 1'b0;
    gw = 1'b0;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (!ga && awready) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bres = bresp;
    bready <= 1'b0;
  endtask : wr

  // Bus read; rready stays high until the answer is sampled
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rdat = rdata;
    rres = rresp;
    rready <= 1'b0;
  endtask : rd

  // Issue one instruction and poll busy so two-cycle forms settle
  task automatic ex(input logic [4:0] op, input logic d, input logic [9:0] im);
    wr(OFF_EXEC, {11'h0, op, 3'h0, d, 2'h0, im});
    do rd(OFF_STATUS); while (rdat[STAT_BUSY] !== 1'b0);
  endtask : ex

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values and the read-only option register
    rd(OFF_STATUS);
    `CHK("status", 32'h18, rdat);
    wr(OFF_OPTION, 32'h0);
    rd(OFF_OPTION);
    `CHK("option", 8'hff, rdat[7:0]);
    wr(8'h40, 32'h1);
    `CHK("bresp", RESP_SLVERR, bres);
    rd(8'h40);
    `CHK("rdata", 32'h0, rdat);
    `CHK("rresp", RESP_SLVERR, rres);
    $display("test reset done");
    wr(OFF_PAGE, 32'h2);
    for (int i = 0; i < NR; i++) begin
      rw = rows[i];
      wr(OFF_ACC, {24'h0, rw.ac});
      wr(OFF_FADDR, {26'h0, rw.im[5:0]});
      wr(OFF_FDATA, {24'h0, rw.r});
      wr(OFF_STATUS, {29'h0, rw.fi});
      wr(OFF_PC, 32'h100);
      ex(rw.op, rw.d, rw.im);
      rd(OFF_ACC);
      `CHK("acc", rw.ea, rdat[7:0]);
      rd(OFF_FDATA);
      `CHK("file", rw.er, rdat[7:0]);
      rd(OFF_STATUS);
      `CHK("flags", rw.ef, rdat[2:0]);
      rd(OFF_PC);
      `CHK("pc", rw.pc, rdat[11:0]);
    end
    $display("test rows done");
    // Global enable through interrupt return, disable and enable
    wr(OFF_STATUS, 32'h0);
    ex(OP_SOFT_INTERRUPT, 1'b0, 10'h0);
    ex(OP_RETURN_FROM_INTERRUPT, 1'b0, 10'h0);
    `CHK("gie", 1'b1, global_interrupt_enable);
    ex(OP_INTERRUPT_DISABLE, 1'b0, 10'h0);
    `CHK("gie", 1'b0, global_interrupt_enable);
    ex(OP_INTERRUPT_ENABLE, 1'b0, 10'h0);
    `CHK("gie", 1'b1, global_interrupt_enable);
    $display("test gie done");
    // Sleep after the watchdog has counted, then an ignored instruction and wake
    ex(OP_SLEEP, 1'b0, 10'h0);
    `CHK("sleep", 1'b1, sleep);
    rd(OFF_STATUS);
    `CHK("to_pd", 2'b01, rdat[STAT_PD:STAT_TO]);
    rd(OFF_WDT);
    `CHK("wdt", 8'h00, rdat[7:0]);
    wr(OFF_ACC, 32'h0);
    ex(OP_LOAD_LITERAL, 1'b0, 10'h77);
    rd(OFF_ACC);
    `CHK("acc", 8'h00, rdat[7:0]);
    wr(OFF_STATUS, 32'h100);
    `CHK("sleep", 1'b0, sleep);
    $display("test sleep done");
    // Slow reader: the answer must stand while rready is held low
    @(posedge clk);
    araddr <= OFF_STATUS;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    repeat (3) @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    `CHK("slow_valid", 1'b1, rvalid);
    `CHK("slow_data", 32'h8, rdata);
    $display("test slow read done");
    give_verdict();
  end
endmodule : mie_core_tb_top

// >>> inc/mie_pkg.sv
// Package for the instruction execute block: offsets, fields, opcodes, reset values and state types
package mie_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_EXEC = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_PAGE = 8'h10;
  localparam logic [7:0] OFF_OPTION = 8'h14;
  localparam logic [7:0] OFF_FADDR = 8'h18;
  localparam logic [7:0] OFF_FDATA = 8'h1c;
  localparam logic [7:0] OFF_WDT = 8'h20;

  // Instruction word fields in the execute register
  localparam int OP_LSB = 16;
  localparam int DEST_BIT = 12;
  localparam int INSTR_W = 21;

  // Status register bit positions
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int STAT_TO = 3;
  localparam int STAT_PD = 4;
  localparam int STAT_GIE = 5;
  localparam int STAT_SLEEP = 6;
  localparam int STAT_BUSY = 7;
  localparam int STAT_WAKE = 8;

  // Opcodes written into the execute register
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_DECREMENT_SKIP_ZERO = 5'h01;
  localparam logic [4:0] OP_INTERRUPT_DISABLE = 5'h02;
  localparam logic [4:0] OP_INTERRUPT_ENABLE = 5'h03;
  localparam logic [4:0] OP_JUMP = 5'h04;
  localparam logic [4:0] OP_SOFT_INTERRUPT = 5'h05;
  localparam logic [4:0] OP_INCREMENT = 5'h06;
  localparam logic [4:0] OP_INCREMENT_SKIP_ZERO = 5'h07;
  localparam logic [4:0] OP_OR_WITH_REGISTER = 5'h08;
  localparam logic [4:0] OP_OR_WITH_LITERAL = 5'h09;
  localparam logic [4:0] OP_PORT_DIRECTION_WRITE = 5'h0a;
  localparam logic [4:0] OP_PORT_DIRECTION_READ = 5'h0b;
  localparam logic [4:0] OP_STORE_ACCUMULATOR = 5'h0c;
  localparam logic [4:0] OP_LOAD_LITERAL = 5'h0d;
  localparam logic [4:0] OP_REGISTER_MOVE = 5'h0e;
  localparam logic [4:0] OP_CONFIG_REGISTER_WRITE = 5'h0f;
  localparam logic [4:0] OP_CONFIG_REGISTER_READ = 5'h10;
  localparam logic [4:0] OP_RETURN_FROM_INTERRUPT = 5'h11;
  localparam logic [4:0] OP_RETURN_WITH_LITERAL = 5'h12;
  localparam logic [4:0] OP_SUBROUTINE_RETURN = 5'h13;
  localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h14;
  localparam logic [4:0] OP_ROTATE_RIGHT_CARRY = 5'h15;
  localparam logic [4:0] OP_SLEEP = 5'h16;
  localparam logic [4:0] OP_SUBTRACT_WITH_BORROW = 5'h17;
  localparam logic [4:0] OP_SUBTRACT_REGISTER = 5'h18;
  localparam logic [4:0] OP_SUBTRACT_FROM_LITERAL = 5'h19;
  localparam logic [4:0] OP_NIBBLE_EXCHANGE = 5'h1a;
  localparam logic [4:0] OP_TABLE_JUMP = 5'h1b;
  localparam logic [4:0] OP_XOR_WITH_REGISTER = 5'h1c;
  localparam logic [4:0] OP_XOR_WITH_LITERAL = 5'h1d;

  // Reset values and fixed addresses
  localparam logic [11:0] RST_PC = 12'h000;
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PD = 1'b1;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [10:0] SOFT_INT_VECTOR = 11'h002;
  localparam logic [7:0] WDT_CLEAR = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SECOND
  } mie_state_type;

  // Whole state of the execute block
  typedef struct packed {
    mie_state_type st;
    logic [INSTR_W-1:0] instr;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic to_bit;
    logic pd_bit;
    logic global_interrupt_enable;
    logic sleep;
    logic [11:0] pc;
    logic [1:0] page;
    logic [7:0] option;
    logic [8:0][7:0] dir;
    logic [63:0][7:0] file;
    logic [4:0][11:0] stack;
    logic [7:0] wdt;
    logic [7:0] wdt_pre;
    logic [5:0] faddr;
    logic awready;
    logic aw_have;
    logic [7:0] awaddr;
    logic wready;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mie_regs_type;

endpackage : mie_pkg

// >>> rtl/mie_core.sv
// Instruction execute unit with its register file, stack and AXI4-Lite register slave
// Notes on behaviour
// RL1 - Decrement-skip: R-1 to dest by d; zero result skips next, two cycles, no flags.
// RL2 - Increment: R+1 to dest by d, only zero flag, one cycle.
// RL3 - Increment-skip: R+1 to dest by d, no flags; zero result skips, two cycles.
// RL4 - Jump: immediate into PC bits 9..0, page bits into 11..10, two cycles.
// RL5 - Soft interrupt: push PC+1, load 002h into PC bits 10..0, two cycles.
// RL6 - OR/XOR with register: result routed by d, only zero flag changes.
// RL7 - OR/XOR with literal: result into accumulator, only zero flag changes.
// RL8 - Port direction write/read: legal registers 5-9 and 12-15, one cycle, no flags.
// RL9 - Store accumulator into any file register 0..63, one cycle, no flags.
// RL10 - Load literal into accumulator in one cycle; unused word bits are zero.
// RL11 - Register move to accumulator or onto itself, always updates zero flag.
// RL12 - Config register write and read via accumulator, one cycle, no flags.
// RL13 - Return from interrupt: pop stack into PC, set global enable, two cycles.
// RL14 - Return with literal: literal to accumulator, pop stack, two cycles, no flags.
// RL15 - Subroutine return: pop stack into PC, two cycles, accumulator and flags kept.
// RL16 - Rotate left through carry; only carry changes.
// RL17 - Rotate right through carry; only carry changes.
// RL18 - Sleep: clear watchdog and prescaler, set timeout bit, clear powerdown bit, sleep.
// RL19 - Subtract with borrow: R + not acc + carry, routed by d, updates C, DC, Z.
// RL20 - Subtract: R or literal minus acc, updates C, DC, Z; literal form writes acc.
// RL21 - Nibble exchange of R, routed by d, no flags.
// RL22 - Table jump: PC low byte plus acc, bits 9..8 kept, page into 11..10, C DC Z.
// RL23 - Interrupt disable clears, interrupt enable sets global enable, one cycle.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module mie_core
  import mie_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic SLEEP_O,
  output logic GIE_O
);

  mie_regs_type q;
  mie_regs_type n;

  // Register view seen by the bus; top bit says whether the offset is mapped
  function automatic logic [32:0] reg_view(input mie_regs_type s, input logic [7:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    case (a)
      OFF_EXEC: v[INSTR_W-1:0] = s.instr;
      OFF_STATUS: begin
        v[STAT_C] = s.c;
        v[STAT_DC] = s.dc;
        v[STAT_Z] = s.z;
        v[STAT_TO] = s.to_bit;
        v[STAT_PD] = s.pd_bit;
        v[STAT_GIE] = s.global_interrupt_enable;
        v[STAT_SLEEP] = s.sleep;
        v[STAT_BUSY] = (s.st != ST_IDLE);
      end
      OFF_ACC: v[7:0] = s.acc;
      OFF_PC: v[11:0] = s.pc;
      OFF_PAGE: v[1:0] = s.page;
      OFF_OPTION: v[7:0] = s.option;
      OFF_FADDR: v[5:0] = s.faddr;
      OFF_FDATA: v[7:0] = s.file[s.faddr];
      OFF_WDT: v[15:0] = {s.wdt_pre, s.wdt};
      default: v[32] = 1'b0;
    endcase
    return v;
  endfunction : reg_view

  // Direction registers exist only at 5..9 and 12..15; packed into slots 0..8
  function automatic logic [4:0] dir_slot(input logic [5:0] r);
    logic [4:0] v;
    v = 5'h00;
    if (r >= 6'h05 && r <= 6'h09) begin
      v = {1'b1, 4'(r - 6'h05)};
    end else if (r >= 6'h0c && r <= 6'h0f) begin
      v = {1'b1, 4'(r - 6'h07)};
    end
    return v;
  endfunction : dir_slot

  logic [4:0] op;
  logic dst;
  logic [7:0] lit;
  logic [5:0] radr;
  logic [7:0] rv;
  logic [7:0] inc_v;
  logic [7:0] dec_v;
  logic [7:0] sub_a;
  logic sub_cin;
  logic [4:0] sub_lo;
  logic [8:0] sub_full;
  logic [4:0] tbl_lo;
  logic [8:0] tbl_full;
  logic [4:0] dslot;
  logic [11:0] pc_next;
  logic [32:0] wview;
  logic [32:0] rview;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic [7:0] res;
  logic res_wr;
  logic wr_go;

  // Operand decode and the shared adders
  always_comb begin
    op = q.instr[OP_LSB +: 5];
    dst = q.instr[DEST_BIT];
    lit = q.instr[7:0];
    radr = q.instr[5:0];
    rv = q.file[radr];
    inc_v = rv + 8'h01;
    dec_v = rv - 8'h01;
    sub_a = (op == OP_SUBTRACT_FROM_LITERAL) ? lit : rv;
    sub_cin = (op == OP_SUBTRACT_WITH_BORROW) ? q.c : 1'b1;
    sub_lo = {1'b0, sub_a[3:0]} + {1'b0, ~q.acc[3:0]} + {4'h0, sub_cin}; // RL19 RL20
    sub_full = {1'b0, sub_a} + {1'b0, ~q.acc} + {8'h00, sub_cin}; // RL19 RL20
    tbl_lo = {1'b0, q.pc[3:0]} + {1'b0, q.acc[3:0]}; // RL22
    tbl_full = {1'b0, q.pc[7:0]} + {1'b0, q.acc}; // RL22
    dslot = dir_slot(radr);
    pc_next = q.pc + 12'h001;
  end

  // Next state: watchdog, bus slave and the execute sequence
  always_comb begin
    n = q;
    res = 8'h00;
    res_wr = 1'b0;
    wview = 33'h0_0000_0000;
    rview = 33'h0_0000_0000;
    wmask = 32'h0000_0000;
    wv = 32'h0000_0000;

    // Watchdog prescaler and counter run freely
    n.wdt_pre = q.wdt_pre + 8'h01;
    if (q.wdt_pre == 8'hff) begin
      n.wdt = q.wdt + 8'h01;
    end

    // Address and data channels are taken independently and held until paired
    if (S_AXI_AWVALID_I && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && q.wready) begin
      n.w_have = 1'b1;
      n.wdata = S_AXI_WDATA_I;
      n.wstrb = S_AXI_WSTRB_I;
    end
    if (q.bvalid && S_AXI_BREADY_I) begin
      n.bvalid = 1'b0;
    end

    // A write waits for the execute sequence to end, so bus and core never fight over a field
    wr_go = q.aw_have && q.w_have && !q.bvalid && (q.st == ST_IDLE);
    if (wr_go) begin
      wview = reg_view(q, q.awaddr);
      wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
      wv = (wview[31:0] & ~wmask) | (q.wdata & wmask);
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wview[32] ? RESP_OKAY : RESP_SLVERR;
      case (q.awaddr)
        OFF_EXEC: begin
          // Sleeping core ignores new instructions until woken
          if (!q.sleep) begin
            n.instr = wv[INSTR_W-1:0];
            n.st = ST_EXEC;
          end
        end
        OFF_STATUS: begin
          n.c = wv[STAT_C];
          n.dc = wv[STAT_DC];
          n.z = wv[STAT_Z];
          n.global_interrupt_enable = wv[STAT_GIE];
          if (wv[STAT_WAKE]) begin
            n.sleep = 1'b0;
          end
        end
        OFF_ACC: n.acc = wv[7:0];
        OFF_PC: n.pc = wv[11:0];
        OFF_PAGE: n.page = wv[1:0];
        OFF_FADDR: n.faddr = wv[5:0];
        OFF_FDATA: n.file[q.faddr] = wv[7:0];
        default: ;
      endcase
    end
    n.awready = !n.aw_have;
    n.wready = !n.w_have;

    // Read channel: one read in flight, answered the cycle after it is taken
    if (q.rvalid && S_AXI_RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && q.arready) begin
      rview = reg_view(q, S_AXI_ARADDR_I);
      n.rvalid = 1'b1;
      n.rdata = rview[31:0];
      n.rresp = rview[32] ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Execute sequence; the second cycle of a branch or skip is a discarded fetch
    unique case (q.st)
      ST_IDLE: ;
      ST_SECOND: n.st = ST_IDLE;
      ST_EXEC: begin
        n.st = ST_IDLE;
        n.pc = pc_next;
        case (op)
          OP_DECREMENT_SKIP_ZERO: begin
            res = dec_v; // RL1
            res_wr = 1'b1;
            if (dec_v == 8'h00) begin
              n.pc = q.pc + 12'h002; // RL1
              n.st = ST_SECOND;
            end
          end
          OP_INCREMENT_SKIP_ZERO: begin
            res = inc_v; // RL3
            res_wr = 1'b1;
            if (inc_v == 8'h00) begin
              n.pc = q.pc + 12'h002; // RL3
              n.st = ST_SECOND;
            end
          end
          OP_INCREMENT: begin
            res = inc_v; // RL2
            res_wr = 1'b1;
            n.z = (inc_v == 8'h00); // RL2
          end
          OP_INTERRUPT_DISABLE: n.global_interrupt_enable = 1'b0; // RL23
          OP_INTERRUPT_ENABLE: n.global_interrupt_enable = 1'b1; // RL23
          OP_JUMP: begin
            n.pc = {q.page, q.instr[9:0]}; // RL4
            n.st = ST_SECOND;
          end
          OP_SOFT_INTERRUPT: begin
            n.stack = {q.stack[3:0], pc_next}; // RL5
            n.pc = {q.pc[11], SOFT_INT_VECTOR}; // RL5
            n.st = ST_SECOND;
          end
          OP_OR_WITH_REGISTER, OP_XOR_WITH_REGISTER: begin
            res = (op == OP_OR_WITH_REGISTER) ? (q.acc | rv) : (q.acc ^ rv); // RL6
            res_wr = 1'b1;
            n.z = (res == 8'h00); // RL6
          end
          OP_OR_WITH_LITERAL, OP_XOR_WITH_LITERAL: begin
            n.acc = (op == OP_OR_WITH_LITERAL) ? (q.acc | lit) : (q.acc ^ lit); // RL7
            n.z = (n.acc == 8'h00); // RL7
          end
          OP_PORT_DIRECTION_WRITE: begin
            // Illegal register numbers are dropped silently
            if (dslot[4]) begin
              n.dir[dslot[3:0]] = q.acc; // RL8
            end
          end
          OP_PORT_DIRECTION_READ: begin
            if (dslot[4]) begin
              n.acc = q.dir[dslot[3:0]]; // RL8
            end
          end
          OP_STORE_ACCUMULATOR: n.file[radr] = q.acc; // RL9
          OP_LOAD_LITERAL: n.acc = lit; // RL10
          OP_REGISTER_MOVE: begin
            res = rv; // RL11
            res_wr = 1'b1;
            n.z = (rv == 8'h00); // RL11
          end
          OP_CONFIG_REGISTER_WRITE: n.option = q.acc; // RL12
          OP_CONFIG_REGISTER_READ: n.acc = q.option; // RL12
          OP_RETURN_FROM_INTERRUPT, OP_RETURN_WITH_LITERAL, OP_SUBROUTINE_RETURN: begin
            // Popping an empty stack returns to address zero
            n.pc = q.stack[0]; // RL13 RL14 RL15
            n.stack = {12'h000, q.stack[4:1]};
            n.st = ST_SECOND;
            if (op == OP_RETURN_FROM_INTERRUPT) begin
              n.global_interrupt_enable = 1'b1; // RL13
            end
            if (op == OP_RETURN_WITH_LITERAL) begin
              n.acc = lit; // RL14
            end
          end
          OP_ROTATE_LEFT_CARRY: begin
            res = {rv[6:0], q.c}; // RL16
            res_wr = 1'b1;
            n.c = rv[7]; // RL16
          end
          OP_ROTATE_RIGHT_CARRY: begin
            res = {q.c, rv[7:1]}; // RL17
            res_wr = 1'b1;
            n.c = rv[0]; // RL17
          end
          OP_SLEEP: begin
            n.wdt = WDT_CLEAR; // RL18
            n.wdt_pre = WDT_CLEAR; // RL18
            n.to_bit = 1'b1; // RL18
            n.pd_bit = 1'b0; // RL18
            n.sleep = 1'b1; // RL18
          end
          OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_REGISTER: begin
            res = sub_full[7:0]; // RL19 RL20
            res_wr = 1'b1;
            n.c = sub_full[8];
            n.dc = sub_lo[4];
            n.z = (sub_full[7:0] == 8'h00);
          end
          OP_SUBTRACT_FROM_LITERAL: begin
            n.acc = sub_full[7:0]; // RL20
            n.c = sub_full[8];
            n.dc = sub_lo[4];
            n.z = (sub_full[7:0] == 8'h00);
          end
          OP_NIBBLE_EXCHANGE: begin
            res = {rv[3:0], rv[7:4]}; // RL21
            res_wr = 1'b1;
          end
          OP_TABLE_JUMP: begin
            n.pc = {q.page, q.pc[9:8], tbl_full[7:0]}; // RL22
            n.c = tbl_full[8];
            n.dc = tbl_lo[4];
            n.z = (tbl_full[7:0] == 8'h00);
          end
          default: ;
        endcase
        // Destination bit steers register-form results
        if (res_wr) begin
          if (dst) begin
            n.file[radr] = res; // RL1 RL2 RL3 RL6 RL11 RL16 RL17 RL19 RL20 RL21
          end else begin
            n.acc = res;
          end
        end
      end
    endcase
  end

  // Single state register; every output is a field of it
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.pc <= RST_PC;
      q.to_bit <= RST_TO;
      q.pd_bit <= RST_PD;
      q.option <= RST_OPTION;
      q.dir <= {9{RST_DIR}};
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign S_AXI_AWREADY_O = q.awready;
  assign S_AXI_WREADY_O = q.wready;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_ARREADY_O = q.arready;
  assign S_AXI_RVALID_O = q.rvalid;
  assign S_AXI_RDATA_O = q.rdata;
  assign S_AXI_RRESP_O = q.rresp;
  assign SLEEP_O = q.sleep;
  assign GIE_O = q.global_interrupt_enable;

endmodule : mie_core
